// ---- hw/ibus_dev.sv ----
`include "ibus_defines.svh"
// What this block does
// - At most 15 devices, 16 signal lines.
// - One active talker, only while addressed.
// - At most 14 listeners at once.
// - One active controller; system controller reclaims.
// - Take control in pass mode, system mode.
// - Listen when commanded, talk returning data.
// - Eight data lines, text or binary.
// - Full handshake per byte before next.
// - Three-wire handshake paced by slowest listener.
// - Controller addresses and commands over management lines.
// - IFC low drops all addressing.
// - ATN low command, high data.
// - Pull SRQ low to request service.
// - Assert SRQ for control when enabled.
// - REN low remote; local key returns unless locked out.
// - REN high returns all to local.
// - EOI marks last byte; controller polls (this block never sends EOI with ATN, so it does not poll).
// - EOI ends input, marks last output.
// - Never answer a parallel poll.
module ibus_dev
  import ibus_pkg::*;
#(
  parameter logic [7:0] IFC_CYC = `IB_IFC_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Bus
  ibus_if.dev bus,
  // Configuration
  input wire logic [4:0] my_addr_in,
  input wire logic sys_mode_in,
  input wire logic pass_mode_in,
  input wire logic srq_en_in,
  // Instrument requests
  input wire logic service_req_in,
  input wire logic ctrl_req_in,
  input wire logic ctrl_release_in,
  input wire logic ifc_req_in,
  input wire logic ren_req_in,
  input wire logic local_key_in,
  // Outgoing bytes
  input wire byte_t tx_data_in,
  input wire logic tx_cmd_in,
  input wire logic tx_last_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // Incoming bytes
  input wire logic rx_hold_in,
  output byte_t rx_data_out,
  output logic rx_end_out,
  output logic rx_valid_out,
  // Status
  output logic talk_out,
  output logic listen_out,
  output logic remote_out,
  output logic lockout_out,
  output logic cic_out,
  output logic srq_out,
  output logic trigger_out,
  output logic clear_out
);
  logic atn_t;
  logic eoi_t;
  logic ifc_t;
  logic ren_t;
  logic ppoll;
  logic src_en;
  logic acc_en;
  logic take;
  logic hs_rx_valid;
  byte_t hs_rx_data;
  logic [1:0] hs_aux;
  byte_t cmd;
  logic is_cmd;
  logic hs_dav;
  logic hs_nrfd;
  logic hs_ndac;
  logic atn_drv_reg;
  logic eoi_drv_reg;
  logic ifc_drv_reg;
  logic ren_drv_reg;
  logic [7:0] ifc_cnt_reg;

  // Bus levels, true when low
  assign atn_t = !bus.ln_lvl[`IB_ATN];
  assign eoi_t = !bus.ln_lvl[`IB_EOI];
  assign ifc_t = !bus.ln_lvl[`IB_IFC];
  assign ren_t = !bus.ln_lvl[`IB_REN];
  assign ppoll = atn_t && eoi_t && !cic_out;

  assign src_en = cic_out || (talk_out && !atn_t);
  assign acc_en = atn_t ? !cic_out : listen_out;
  assign take = tx_valid_in && tx_ready_out;
  assign cmd = hs_rx_data & `IB_CMD_MASK;
  assign is_cmd = hs_rx_valid && hs_aux[1] && !cic_out;

  assign bus.dev_ln_out = 8'h00;
  assign bus.dev_ln_oe = {eoi_drv_reg, ren_drv_reg, srq_out, atn_drv_reg,
                         ifc_drv_reg, hs_ndac, hs_nrfd, hs_dav};

  ibus_hs u_hs (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .src_en_in(src_en),
    .acc_en_in(acc_en),
    .acc_hold_in(rx_hold_in),
    .quiet_in(ppoll),
    .tx_data_in(tx_data_in),
    .tx_valid_in(tx_valid_in),
    .tx_ready_out(tx_ready_out),
    .aux_in({atn_t, eoi_t}),
    .rx_data_out(hs_rx_data),
    .rx_aux_out(hs_aux),
    .rx_valid_out(hs_rx_valid),
    .dio_in(bus.dio_lvl),
    .ln_in(bus.ln_lvl),
    .dio_out(bus.dev_dio_out),
    .dio_oe_out(bus.dev_dio_oe),
    .dav_oe_out(hs_dav),
    .nrfd_oe_out(hs_nrfd),
    .ndac_oe_out(hs_ndac)
  );

  // Talk and listen addressing
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || ifc_t) begin
      talk_out <= 1'b0;
      listen_out <= 1'b0;
    end else if (is_cmd) begin
      if (is_lag(cmd, my_addr_in)) begin
        listen_out <= 1'b1;
        talk_out <= 1'b0;
      end else if (is_tag(cmd, my_addr_in)) begin
        talk_out <= 1'b1;
        listen_out <= 1'b0;
      end else if (cmd == `IB_UNL) begin
        listen_out <= 1'b0;
      end else if (in_tag_grp(cmd)) begin
        talk_out <= 1'b0;
      end
    end
  end

  // Controller role
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cic_out <= 1'b0;
    end else if (sys_mode_in) begin
      cic_out <= 1'b1;
    end else if (ifc_t || ctrl_release_in) begin
      cic_out <= 1'b0;
    end else if (is_cmd && cmd == `IB_TCT && talk_out && pass_mode_in) begin
      cic_out <= 1'b1;
    end
  end

  // Attention and end-of-message drive
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      atn_drv_reg <= 1'b0;
      eoi_drv_reg <= 1'b0;
    end else if (take) begin
      atn_drv_reg <= cic_out && tx_cmd_in;
      eoi_drv_reg <= tx_last_in && !(cic_out && tx_cmd_in);
    end else begin
      if (!cic_out || ctrl_release_in) begin
        atn_drv_reg <= 1'b0;
      end
      if (tx_ready_out || !src_en || (hs_dav && bus.ln_lvl[`IB_NDAC])) begin
        eoi_drv_reg <= 1'b0;
      end
    end
  end

  // Interface clear and remote enable as system controller
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !sys_mode_in) begin
      ifc_drv_reg <= 1'b0;
      ren_drv_reg <= 1'b0;
      ifc_cnt_reg <= 8'h00;
    end else begin
      ren_drv_reg <= ren_req_in;
      if (ifc_req_in && !ifc_drv_reg) begin
        ifc_drv_reg <= 1'b1;
        ifc_cnt_reg <= IFC_CYC;
      end else if (ifc_cnt_reg != 8'h00) begin
        ifc_cnt_reg <= ifc_cnt_reg - 8'h01;
      end else begin
        ifc_drv_reg <= 1'b0;
      end
    end
  end

  // Remote and local lockout
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !ren_t) begin
      remote_out <= 1'b0;
      lockout_out <= 1'b0;
    end else begin
      if (is_cmd && cmd == `IB_LLO) begin
        lockout_out <= 1'b1;
      end
      if (is_cmd && is_lag(cmd, my_addr_in)) begin
        remote_out <= 1'b1;
      end else if (is_cmd && listen_out && cmd == `IB_GTL) begin
        remote_out <= 1'b0;
      end else if (local_key_in && !lockout_out) begin
        remote_out <= 1'b0;
      end
    end
  end

  // Service request
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      srq_out <= 1'b0;
    end else begin
      srq_out <= srq_en_in && !cic_out &&
                 (service_req_in || (pass_mode_in && ctrl_req_in));
    end
  end

  // Received data and device commands
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_end_out <= 1'b0;
      trigger_out <= 1'b0;
      clear_out <= 1'b0;
    end else begin
      rx_valid_out <= hs_rx_valid && !hs_aux[1] && listen_out && !cic_out;
      if (hs_rx_valid && !hs_aux[1]) begin
        rx_data_out <= hs_rx_data;
        rx_end_out <= hs_aux[0];
      end
      trigger_out <= is_cmd && listen_out && cmd == `IB_GET;
      clear_out <= is_cmd && (cmd == `IB_DCL || (listen_out && cmd == `IB_SDC));
    end
  end
endmodule

// ---- hw/ibus_defines.svh ----
`ifndef IBUS_DEFINES_SVH
`define IBUS_DEFINES_SVH
`define IB_DAV 3'h0
`define IB_NRFD 3'h1
`define IB_NDAC 3'h2
`define IB_IFC 3'h3
`define IB_ATN 3'h4
`define IB_SRQ 3'h5
`define IB_REN 3'h6
`define IB_EOI 3'h7
`define IB_CMD_MASK 8'h7F
`define IB_GRP_MASK 8'h60
`define IB_LAG_GRP 8'h20
`define IB_TAG_GRP 8'h40
`define IB_UNL 8'h3F
`define IB_UNT 8'h5F
`define IB_GTL 8'h01
`define IB_SDC 8'h04
`define IB_GET 8'h08
`define IB_TCT 8'h09
`define IB_LLO 8'h11
`define IB_DCL 8'h14
`define IB_SETTLE_CYC 4'h2
`define IB_IFC_CYC 8'h40
`endif

// ---- hw/ibus_pkg.sv ----
`include "ibus_defines.svh"
package ibus_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {SRC_IDLE, SRC_SETTLE, SRC_DAV} src_state_e;
  typedef enum logic [1:0] {ACC_IDLE, ACC_READY, ACC_TAKEN} acc_state_e;

  function automatic logic is_lag(input byte_t c, input logic [4:0] a);
    return c == (`IB_LAG_GRP | {3'h0, a});
  endfunction

  function automatic logic is_tag(input byte_t c, input logic [4:0] a);
    return c == (`IB_TAG_GRP | {3'h0, a});
  endfunction

  function automatic logic in_tag_grp(input byte_t c);
    return (c & `IB_GRP_MASK) == `IB_TAG_GRP;
  endfunction
endpackage

// ---- hw/ibus_if.sv ----
interface ibus_if;
  logic [7:0] dev_dio_out;
  logic dev_dio_oe;
  logic [7:0] dev_ln_out;
  logic [7:0] dev_ln_oe;
  logic [7:0] ctl_dio_out;
  logic ctl_dio_oe;
  logic [7:0] ctl_ln_out;
  logic [7:0] ctl_ln_oe;
  logic [7:0] dio_lvl;
  logic [7:0] ln_lvl;

  // Wired-and resolution of both ends
  assign dio_lvl = (dev_dio_oe ? dev_dio_out : 8'hFF) & (ctl_dio_oe ? ctl_dio_out : 8'hFF);
  assign ln_lvl = (dev_ln_out | ~dev_ln_oe) & (ctl_ln_out | ~ctl_ln_oe);

  modport dev (input dio_lvl, ln_lvl, output dev_dio_out, dev_dio_oe, dev_ln_out, dev_ln_oe);
  modport ctl (input dio_lvl, ln_lvl, output ctl_dio_out, ctl_dio_oe, ctl_ln_out, ctl_ln_oe);
endinterface

// ---- hw/ibus_hs.sv ----
`include "ibus_defines.svh"
module ibus_hs
  import ibus_pkg::*;
#(
  parameter logic [3:0] SETTLE = `IB_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Roles
  input wire logic src_en_in,
  input wire logic acc_en_in,
  input wire logic acc_hold_in,
  input wire logic quiet_in,
  // Send side
  input wire byte_t tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // Receive side
  input wire logic [1:0] aux_in,
  output byte_t rx_data_out,
  output logic [1:0] rx_aux_out,
  output logic rx_valid_out,
  // Bus lines
  input wire byte_t dio_in,
  input wire logic [7:0] ln_in,
  output byte_t dio_out,
  output logic dio_oe_out,
  output logic dav_oe_out,
  output logic nrfd_oe_out,
  output logic ndac_oe_out
);
  src_state_e src_reg;
  acc_state_e acc_reg;
  logic [3:0] cnt_reg;
  logic take;

  assign take = tx_valid_in && tx_ready_out;

  // Source handshake
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      src_reg <= SRC_IDLE;
      tx_ready_out <= 1'b0;
      dio_oe_out <= 1'b0;
      dav_oe_out <= 1'b0;
      dio_out <= 8'hFF;
      cnt_reg <= 4'h0;
    end else if (!src_en_in || quiet_in) begin
      src_reg <= SRC_IDLE;
      tx_ready_out <= 1'b0;
      dio_oe_out <= 1'b0;
      dav_oe_out <= 1'b0;
    end else begin
      case (src_reg)
        SRC_IDLE: begin
          tx_ready_out <= !take;
          if (take) begin
            dio_out <= tx_data_in;
            dio_oe_out <= 1'b1;
            cnt_reg <= SETTLE;
            src_reg <= SRC_SETTLE;
          end
        end
        SRC_SETTLE: begin
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else if (ln_in[`IB_NRFD]) begin
            dav_oe_out <= 1'b1;
            src_reg <= SRC_DAV;
          end
        end
        SRC_DAV: begin
          if (ln_in[`IB_NDAC]) begin
            dav_oe_out <= 1'b0;
            dio_oe_out <= 1'b0;
            tx_ready_out <= 1'b1;
            src_reg <= SRC_IDLE;
          end
        end
        default: src_reg <= SRC_IDLE;
      endcase
    end
  end

  // Acceptor handshake
  always_ff @(posedge clk_sys_in) begin
    rx_valid_out <= 1'b0;
    if (rst_in) begin
      acc_reg <= ACC_IDLE;
      nrfd_oe_out <= 1'b0;
      ndac_oe_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_aux_out <= 2'h0;
    end else if (!acc_en_in || quiet_in) begin
      acc_reg <= ACC_IDLE;
      nrfd_oe_out <= 1'b0;
      ndac_oe_out <= 1'b0;
    end else begin
      case (acc_reg)
        ACC_IDLE: begin
          nrfd_oe_out <= 1'b1;
          ndac_oe_out <= 1'b1;
          acc_reg <= ACC_READY;
        end
        ACC_READY: begin
          nrfd_oe_out <= acc_hold_in;
          ndac_oe_out <= 1'b1;
          if (!ln_in[`IB_DAV] && !nrfd_oe_out) begin
            rx_data_out <= dio_in;
            rx_aux_out <= aux_in;
            rx_valid_out <= 1'b1;
            nrfd_oe_out <= 1'b1;
            ndac_oe_out <= 1'b0;
            acc_reg <= ACC_TAKEN;
          end
        end
        ACC_TAKEN: begin
          if (ln_in[`IB_DAV]) begin
            ndac_oe_out <= 1'b1;
            acc_reg <= ACC_READY;
          end
        end
        default: acc_reg <= ACC_IDLE;
      endcase
    end
  end
endmodule

// ---- hw/ibus_ctl.sv ----
`include "ibus_defines.svh"
module ibus_ctl
  import ibus_pkg::*;
#(
  parameter logic [7:0] IFC_CYC = `IB_IFC_CYC
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Bus
  ibus_if.ctl bus,
  // Control requests
  input wire logic [4:0] my_addr_in,
  input wire logic ifc_req_in,
  input wire logic ren_in,
  input wire logic pass_ctrl_in,
  input wire logic listen_in,
  // Outgoing bytes
  input wire byte_t tx_data_in,
  input wire logic tx_cmd_in,
  input wire logic tx_last_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // Incoming bytes
  input wire logic rx_hold_in,
  output byte_t rx_data_out,
  output logic rx_end_out,
  output logic rx_valid_out,
  // Status
  output logic active_out,
  output logic srq_out
);
  logic atn_t;
  logic src_en;
  logic acc_en;
  logic take;
  logic hs_rx_valid;
  byte_t hs_rx_data;
  logic [1:0] hs_aux;
  byte_t cmd;
  logic is_cmd;
  logic hs_dav;
  logic hs_nrfd;
  logic hs_ndac;
  logic atn_drv_reg;
  logic eoi_drv_reg;
  logic ifc_drv_reg;
  logic ren_drv_reg;
  logic addressed_reg;
  logic [7:0] ifc_cnt_reg;

  assign atn_t = !bus.ln_lvl[`IB_ATN];
  assign src_en = active_out;
  assign acc_en = atn_t ? !active_out : listen_in;
  assign take = tx_valid_in && tx_ready_out;
  assign cmd = hs_rx_data & `IB_CMD_MASK;
  assign is_cmd = hs_rx_valid && hs_aux[1] && !active_out;

  assign bus.ctl_ln_out = 8'h00;
  assign bus.ctl_ln_oe = {eoi_drv_reg, ren_drv_reg, 1'b0, atn_drv_reg,
                         ifc_drv_reg, hs_ndac, hs_nrfd, hs_dav};

  ibus_hs u_hs (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .src_en_in(src_en),
    .acc_en_in(acc_en),
    .acc_hold_in(rx_hold_in),
    .quiet_in(1'b0),
    .tx_data_in(tx_data_in),
    .tx_valid_in(tx_valid_in),
    .tx_ready_out(tx_ready_out),
    .aux_in({atn_t, !bus.ln_lvl[`IB_EOI]}),
    .rx_data_out(hs_rx_data),
    .rx_aux_out(hs_aux),
    .rx_valid_out(hs_rx_valid),
    .dio_in(bus.dio_lvl),
    .ln_in(bus.ln_lvl),
    .dio_out(bus.ctl_dio_out),
    .dio_oe_out(bus.ctl_dio_oe),
    .dav_oe_out(hs_dav),
    .nrfd_oe_out(hs_nrfd),
    .ndac_oe_out(hs_ndac)
  );

  // Interface clear and remote enable
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ifc_drv_reg <= 1'b0;
      ren_drv_reg <= 1'b0;
      ifc_cnt_reg <= 8'h00;
    end else begin
      ren_drv_reg <= ren_in;
      if (ifc_req_in && !ifc_drv_reg) begin
        ifc_drv_reg <= 1'b1;
        ifc_cnt_reg <= IFC_CYC;
      end else if (ifc_cnt_reg != 8'h00) begin
        ifc_cnt_reg <= ifc_cnt_reg - 8'h01;
      end else begin
        ifc_drv_reg <= 1'b0;
      end
    end
  end

  // Active control, passed out and taken back
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      active_out <= 1'b1;
      addressed_reg <= 1'b0;
    end else if (ifc_drv_reg) begin
      active_out <= 1'b1;
      addressed_reg <= 1'b0;
    end else if (pass_ctrl_in) begin
      active_out <= 1'b0;
    end else if (is_cmd) begin
      if (is_tag(cmd, my_addr_in)) begin
        addressed_reg <= 1'b1;
      end else if (in_tag_grp(cmd)) begin
        addressed_reg <= 1'b0;
      end else if (cmd == `IB_TCT && addressed_reg) begin
        active_out <= 1'b1;
      end
    end
  end

  // Attention and end-of-message drive
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      atn_drv_reg <= 1'b0;
      eoi_drv_reg <= 1'b0;
    end else if (take) begin
      atn_drv_reg <= tx_cmd_in;
      eoi_drv_reg <= tx_last_in;
    end else begin
      // Idle source drops attention so the addressed talker may send
      if (!active_out || pass_ctrl_in || (tx_ready_out && !tx_valid_in)) begin
        atn_drv_reg <= 1'b0;
      end
      if (tx_ready_out || !src_en) begin
        eoi_drv_reg <= 1'b0;
      end
    end
  end

  // Service request and received data
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      srq_out <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_end_out <= 1'b0;
    end else begin
      srq_out <= !bus.ln_lvl[`IB_SRQ];
      rx_valid_out <= hs_rx_valid && !hs_aux[1];
      if (hs_rx_valid && !hs_aux[1]) begin
        rx_data_out <= hs_rx_data;
        rx_end_out <= hs_aux[0];
      end
    end
  end
endmodule

// ---- verif/ibus_monitor.sv ----
module ibus_monitor (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Bus drives and levels
  input wire logic dev_dio_oe,
  input wire logic [7:0] dev_ln_oe,
  input wire logic ctl_dio_oe,
  input wire logic [7:0] ctl_ln_oe,
  input wire logic [7:0] dio_lvl,
  input wire logic [7:0] ln_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  a_dav_with_data: assert property ((dev_ln_oe[0] -> dev_dio_oe) && (ctl_ln_oe[0] -> ctl_dio_oe))
    else $error("DAV pulled without data");
  a_one_talker: assert property (!(dev_dio_oe && ctl_dio_oe))
    else $error("two ends drive data");
  a_dav_waits_nrfd: assert property ($fell(ln_lvl[0]) |-> $past(ln_lvl[1]))
    else $error("DAV while not ready");
  a_data_held: assert property (!ln_lvl[0] && $past(!ln_lvl[0]) |-> $stable(dio_lvl))
    else $error("data moved under DAV");
  a_nrfd_after_dav: assert property ($fell(ln_lvl[0]) && (ln_lvl[4] || ln_lvl[7]) |-> ##[0:2] !ln_lvl[1])
    else $error("acceptor missed DAV");
  a_dav_release: assert property ($rose(ln_lvl[2]) && !ln_lvl[0] |-> ##[1:2] ln_lvl[0])
    else $error("DAV kept after NDAC");
  a_ifc_drops_talk: assert property ($fell(ln_lvl[3]) |-> ##[1:4] (!dev_dio_oe && !dev_ln_oe[0]))
    else $error("talker kept after IFC");
  a_dev_no_mgmt: assert property (!(dev_ln_oe[3] || dev_ln_oe[4] || dev_ln_oe[6]))
    else $error("device drove IFC ATN or REN");
  a_poll_silent: assert property ((!ln_lvl[4] && !ln_lvl[7])[*3] |-> !(dev_dio_oe || dev_ln_oe[1] || dev_ln_oe[2]))
    else $error("device answered poll");
  a_host_no_srq: assert property (!ctl_ln_oe[5])
    else $error("host pulled SRQ");
  a_eoi_with_byte: assert property (dev_ln_oe[7] |-> dev_dio_oe)
    else $error("EOI without byte");
endmodule

// ---- verif/tb.sv ----
`define CHK(g, e) begin got = 16'(g); exp = 16'(e); check_count++; if (got !== exp) begin \
  fails++; $display("ERROR %0t: got %h exp %h", $time, got, exp); end end
module tb import ibus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] ADDR = 5'h07;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  int fails = 0;
  int check_count = 0;
  int trig_n = 0;
  int clr_n = 0;
  logic [15:0] got, exp;
  byte_t tx_data = 8'h00;
  logic tx_cmd = 1'b0, tx_last = 1'b0, d_valid = 1'b0, c_valid = 1'b0, d_hold = 1'b0;
  logic pass_mode = 1'b0, srq_en = 1'b1, svc = 1'b0, ctrl_req = 1'b0, lkey = 1'b0;
  logic c_ifc = 1'b0, ren = 1'b1, c_listen = 1'b0;
  logic sys_mode = 1'b0, ctrl_rel = 1'b0, pass_ctrl = 1'b0;
  logic cic, active;
  logic d_ready, c_ready, d_rx_end, c_rx_end, d_rx_valid, c_rx_valid;
  logic talk, listen, remote, lockout, d_srq, c_srq, trig, clr;
  byte_t d_rx_data, c_rx_data;
  logic [8:0] dq[$], cq[$];

  always #25 clk_sys_in = ~clk_sys_in;

  ibus_if bus();
  ibus_dev #(.IFC_CYC(8'h04)) ibus_dev_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .bus(bus), .my_addr_in(ADDR), .sys_mode_in(sys_mode), .pass_mode_in(pass_mode),
    .srq_en_in(srq_en), .service_req_in(svc), .ctrl_req_in(ctrl_req),
    .ctrl_release_in(ctrl_rel), .ifc_req_in(1'b0), .ren_req_in(1'b0), .local_key_in(lkey),
    .tx_data_in(tx_data), .tx_cmd_in(tx_cmd), .tx_last_in(tx_last), .tx_valid_in(d_valid),
    .tx_ready_out(d_ready), .rx_hold_in(d_hold), .rx_data_out(d_rx_data),
    .rx_end_out(d_rx_end), .rx_valid_out(d_rx_valid), .talk_out(talk),
    .listen_out(listen), .remote_out(remote), .lockout_out(lockout), .cic_out(cic),
    .srq_out(d_srq), .trigger_out(trig), .clear_out(clr));
  ibus_ctl #(.IFC_CYC(8'h04)) ibus_ctl_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .bus(bus), .my_addr_in(5'h00), .ifc_req_in(c_ifc), .ren_in(ren),
    .pass_ctrl_in(pass_ctrl),
    .listen_in(c_listen), .tx_data_in(tx_data), .tx_cmd_in(tx_cmd), .tx_last_in(tx_last),
    .tx_valid_in(c_valid), .tx_ready_out(c_ready), .rx_hold_in(d_hold),
    .rx_data_out(c_rx_data), .rx_end_out(c_rx_end), .rx_valid_out(c_rx_valid),
    .active_out(active), .srq_out(c_srq));
  ibus_monitor ibus_monitor_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .dev_dio_oe(bus.dev_dio_oe), .dev_ln_oe(bus.dev_ln_oe), .ctl_dio_oe(bus.ctl_dio_oe),
    .ctl_ln_oe(bus.ctl_ln_oe), .dio_lvl(bus.dio_lvl), .ln_lvl(bus.ln_lvl));

  // Collect received bytes and pulses
  always @(posedge clk_sys_in) begin
    if (d_rx_valid === 1'b1) dq.push_back({d_rx_end, d_rx_data});
    if (c_rx_valid === 1'b1) cq.push_back({c_rx_end, c_rx_data});
    if (trig === 1'b1) trig_n++;
    if (clr === 1'b1) clr_n++;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  // One byte from either end, held until taken, then waits for completion
  task automatic put(input bit from_dev, input byte_t b, input logic cmd, input logic last);
    int n;
    n = 0;
    @(negedge clk_sys_in);
    tx_data = b;
    tx_cmd = cmd;
    tx_last = last;
    if (from_dev) d_valid = 1'b1;
    else c_valid = 1'b1;
    while ((from_dev ? d_ready : c_ready) !== 1'b1 && n < 400) begin
      @(negedge clk_sys_in);
      n++;
    end
    @(negedge clk_sys_in);
    d_valid = 1'b0;
    c_valid = 1'b0;
    while ((from_dev ? d_ready : c_ready) !== 1'b1 && n < 800) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK(n < 800, 1'b1)
    wait_n(3);
  endtask

  initial begin
    #(50 * 20000);
    fails++;
    $display("ERROR %0t: timeout", $time);
    complete_run();
  end

  initial begin
    wait_n(16);
    rst_in = 1'b0;
    wait_n(4);
    put(0, {3'h1, ADDR}, 1, 0);
    `CHK(listen, 1'b1)
    `CHK(remote, 1'b1)
    put(0, 8'hA5, 0, 0);
    put(0, 8'h3C, 0, 1);
    `CHK(dq.pop_front(), 9'h0A5)
    `CHK(dq.pop_front(), 9'h13C)
    $display("test listen done");
    d_hold = 1'b1;
    fork
      put(0, 8'h5A, 0, 0);
      begin
        wait_n(30);
        `CHK(dq.size(), 0)
        `CHK(c_ready, 1'b0)
        d_hold = 1'b0;
      end
    join
    `CHK(dq.pop_front(), 9'h05A)
    $display("test stall done");
    put(0, 8'h08, 1, 0);
    put(0, 8'h04, 1, 0);
    put(0, 8'h14, 1, 0);
    `CHK(trig_n, 1)
    `CHK(clr_n, 2)
    `CHK(dq.size(), 0)
    lkey = 1'b1;
    wait_n(3);
    lkey = 1'b0;
    `CHK(remote, 1'b0)
    put(0, {3'h1, ADDR}, 1, 0);
    put(0, 8'h11, 1, 0);
    `CHK(lockout, 1'b1)
    lkey = 1'b1;
    wait_n(3);
    lkey = 1'b0;
    `CHK(remote, 1'b1)
    ren = 1'b0;
    wait_n(4);
    `CHK(remote, 1'b0)
    `CHK(lockout, 1'b0)
    $display("test commands done");
    put(0, 8'h3F, 1, 0);
    put(0, {3'h2, ADDR}, 1, 0);
    `CHK(talk, 1'b1)
    `CHK(listen, 1'b0)
    c_listen = 1'b1;
    put(1, 8'h11, 0, 0);
    put(1, 8'hEE, 0, 1);
    `CHK(cq.pop_front(), 9'h011)
    `CHK(cq.pop_front(), 9'h1EE)
    c_listen = 1'b0;
    put(0, 8'h5F, 1, 0);
    `CHK(talk, 1'b0)
    $display("test talk done");
    put(0, {3'h2, ADDR}, 1, 1);
    `CHK(dq.size(), 0)
    `CHK(talk, 1'b0)
    $display("test poll done");
    put(0, {3'h2, ADDR}, 1, 0);
    `CHK(talk, 1'b1)
    c_ifc = 1'b1;
    wait_n(1);
    c_ifc = 1'b0;
    wait_n(16);
    `CHK(talk, 1'b0)
    `CHK(listen, 1'b0)
    $display("test clear done");
    svc = 1'b1;
    wait_n(4);
    `CHK(d_srq, 1'b1)
    `CHK(c_srq, 1'b1)
    svc = 1'b0;
    wait_n(4);
    `CHK(c_srq, 1'b0)
    pass_mode = 1'b1;
    ctrl_req = 1'b1;
    wait_n(4);
    `CHK(c_srq, 1'b1)
    srq_en = 1'b0;
    wait_n(4);
    `CHK(d_srq, 1'b0)
    $display("test service done");
    put(0, {3'h2, ADDR}, 1, 0);
    put(0, 8'h09, 1, 0);
    `CHK(cic, 1'b1)
    pass_ctrl = 1'b1;
    wait_n(1);
    pass_ctrl = 1'b0;
    wait_n(2);
    `CHK(active, 1'b0)
    ctrl_rel = 1'b1;
    wait_n(1);
    ctrl_rel = 1'b0;
    wait_n(2);
    `CHK(cic, 1'b0)
    c_ifc = 1'b1;
    wait_n(1);
    c_ifc = 1'b0;
    wait_n(8);
    `CHK(active, 1'b1)
    sys_mode = 1'b1;
    wait_n(2);
    `CHK(cic, 1'b1)
    sys_mode = 1'b0;
    ctrl_rel = 1'b1;
    wait_n(1);
    ctrl_rel = 1'b0;
    wait_n(2);
    `CHK(cic, 1'b0)
    $display("test control done");
    complete_run();
  end
endmodule
